// *** include/vsfr_regs.svh ***
// timing counts and reset values of the valley switching frequency reducer
`ifndef VSFR_REGS_SVH
`define VSFR_REGS_SVH
`define VSFR_CLK_HZ          50000000
`define VSFR_SS_TIME_MS      12
`define VSFR_SS_STEPS        4
`define VSFR_SS_STEP_CYC     ((`VSFR_CLK_HZ / 1000) * `VSFR_SS_TIME_MS / `VSFR_SS_STEPS)
`define VSFR_PERIOD_MS       48
`define VSFR_PERIOD_CYC      ((`VSFR_CLK_HZ / 1000) * `VSFR_PERIOD_MS)
`define VSFR_MIN_SWFREQ_HZ   20000
`define VSFR_MAX_OFF_CYC     (`VSFR_CLK_HZ / `VSFR_MIN_SWFREQ_HZ)
`define VSFR_RING_SUP_NS     2500
`define VSFR_RING_SUP_CYC    ((`VSFR_RING_SUP_NS + 19) / 20)
`define VSFR_OVP_BLANK_NS    1000
`define VSFR_OVP_BLANK_CYC   ((`VSFR_OVP_BLANK_NS + 19) / 20)
`define VSFR_TARGET_MIN      3'h1
`define VSFR_TARGET_MAX      3'h7
`define VSFR_VALLEY_MAX      3'h7
`define VSFR_SS_FIRST        2'h0
`define VSFR_SS_LAST         2'h3
`endif

// *** include/vsfr_pkg.sv ***
// types of the valley switching frequency reducer
package vsfr_pkg;
    typedef enum logic [1:0] {
        VSFR_IDLE   = 2'b00,
        VSFR_OFF    = 2'b01,
        VSFR_ON     = 2'b10,
        VSFR_LATCH  = 2'b11
    } vsfr_state_type;

    // comparator levels from the analog front end
    typedef struct packed {
        logic lowHold;
        logic highHold;
        logic resetLevel;
    } vsfr_fb_type;

    // sticky threshold flags of one counting period
    typedef struct packed {
        logic sawLow;
        logic sawHigh;
        logic sawReset;
    } vsfr_flags_type;
endpackage

// *** core/vsfr_core.sv ***
// digital control core: soft-start, valley target counter, valley count, gate timing
`timescale 1ns/100ps
`include "vsfr_regs.svh"

// What this block does
// - supply ready stops charger, starts soft-start
// - four 3 ms current limit steps
// - valleys switch on, comparator switches off
// - evaluate feedback thresholds every 48 ms
// - always below low hold: increment, max 7
// - above low, below high: hold value
// - above high, below reset: decrement, min 1
// - above reset: force target to 1
// - target kept within 1 to 7
// - target starts at 1
// - line level selects hold threshold set
// - valley count 0 to 7, saturating
// - each falling valley crossing in the off state increments count
// - gate rising clears valley count
// - off-time overvoltage latches off after blanking
// - after suppression, on when count reaches target
// - no turn-on during ringing suppression time
// - turn on after maximum off time
module vsfr_core
    import vsfr_pkg::*;
#(
    parameter int PERIOD_CYC  = `VSFR_PERIOD_CYC,
    parameter int SS_STEP_CYC = `VSFR_SS_STEP_CYC
) (
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    // analog comparators
    input  wire logic        supplyTurnOn,
    input  wire logic        valleySense,
    input  wire logic        outputOvervoltage,
    input  wire logic        currentTrip,
    input  wire logic        highLine,
    input  wire vsfr_fb_type feedbackPin,
    // outputs to the analog side
    output logic             gateDrive,
    output logic             startupChargeEn,
    output logic [1:0]       csLimitStep,
    output logic             softStartDone,
    output logic             highLineSelect,
    output logic [2:0]       valleyTarget,
    output logic [2:0]       valleyCount,
    output logic             latchedOff
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic        supplyS1_r, supplyS2_r;
    logic        valleyS1_r, valleyS2_r, valleyS3_r;
    logic        ovpS1_r, ovpS2_r;
    logic        tripS1_r, tripS2_r;
    logic        lineS1_r, lineS2_r;
    vsfr_fb_type fbS1_r, fbS2_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {supplyS1_r, supplyS2_r} <= 2'h0;
            {valleyS1_r, valleyS2_r, valleyS3_r} <= 3'h0;
            {ovpS1_r, ovpS2_r} <= 2'h0;
            {tripS1_r, tripS2_r} <= 2'h0;
            {lineS1_r, lineS2_r} <= 2'h0;
            fbS1_r <= '0;
            fbS2_r <= '0;
        end else if (clkEn) begin
            supplyS1_r <= supplyTurnOn;
            supplyS2_r <= supplyS1_r;
            valleyS1_r <= valleySense;
            valleyS2_r <= valleyS1_r;
            valleyS3_r <= valleyS2_r;
            ovpS1_r    <= outputOvervoltage;
            ovpS2_r    <= ovpS1_r;
            tripS1_r   <= currentTrip;
            tripS2_r   <= tripS1_r;
            lineS1_r   <= highLine;
            lineS2_r   <= lineS1_r;
            fbS1_r     <= feedbackPin;
            fbS2_r     <= fbS1_r;
        end
    end

    logic valleyFall;
    assign valleyFall = valleyS3_r & ~valleyS2_r;

    // ----------------------------------------
    // gate state machine
    // ----------------------------------------
    vsfr_state_type state_r, state_nxt;
    logic [15:0]    offCnt_r;
    logic [15:0]    ovpCnt_r;
    logic           ringDone;
    logic           maxOffHit;
    logic           ovpFire;

    assign ringDone  = offCnt_r >= 16'(`VSFR_RING_SUP_CYC);
    assign maxOffHit = offCnt_r >= 16'(`VSFR_MAX_OFF_CYC - 1);
    assign ovpFire   = ovpS2_r && ovpCnt_r >= 16'(`VSFR_OVP_BLANK_CYC - 1);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            VSFR_IDLE: begin
                if (supplyS2_r) begin
                    state_nxt = VSFR_OFF;
                end
            end
            VSFR_OFF: begin
                if (ovpFire) begin
                    state_nxt = VSFR_LATCH;
                end else if (maxOffHit) begin
                    state_nxt = VSFR_ON;
                end else if (ringDone && valleyCount >= valleyTarget) begin
                    state_nxt = VSFR_ON;
                end
            end
            VSFR_ON: begin
                if (tripS2_r) begin
                    state_nxt = VSFR_OFF;
                end
            end
            VSFR_LATCH: begin
                state_nxt = VSFR_LATCH;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= VSFR_IDLE;
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gateDrive       <= 1'b0;
            startupChargeEn <= 1'b1;
            latchedOff      <= 1'b0;
        end else if (clkEn) begin
            gateDrive <= (state_nxt == VSFR_ON);
            if (state_nxt != VSFR_IDLE) begin
                startupChargeEn <= 1'b0;
            end
            latchedOff <= (state_nxt == VSFR_LATCH);
        end
    end

    // off-time counter drives suppression and maximum off time
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            offCnt_r <= 16'h0;
        end else if (clkEn) begin
            if (state_r != VSFR_OFF) begin
                offCnt_r <= 16'h0;
            end else if (offCnt_r != 16'hffff) begin
                offCnt_r <= offCnt_r + 16'h1;
            end
        end
    end

    // overvoltage blanking counter, off-time only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ovpCnt_r <= 16'h0;
        end else if (clkEn) begin
            if (state_r != VSFR_OFF || !ovpS2_r) begin
                ovpCnt_r <= 16'h0;
            end else if (ovpCnt_r != 16'hffff) begin
                ovpCnt_r <= ovpCnt_r + 16'h1;
            end
        end
    end

    // ----------------------------------------
    // valley counter
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            valleyCount <= 3'h0;
        end else if (clkEn) begin
            if (state_nxt == VSFR_ON && state_r != VSFR_ON) begin
                valleyCount <= 3'h0;
            end else if (state_r == VSFR_OFF && valleyFall
                         && valleyCount != `VSFR_VALLEY_MAX) begin
                valleyCount <= valleyCount + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // soft-start
    // ----------------------------------------
    logic [31:0] ssCnt_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ssCnt_r       <= 32'h0;
            csLimitStep   <= `VSFR_SS_FIRST;
            softStartDone <= 1'b0;
        end else if (clkEn && state_r != VSFR_IDLE && !softStartDone) begin
            if (ssCnt_r >= 32'(SS_STEP_CYC - 1)) begin
                ssCnt_r <= 32'h0;
                if (csLimitStep == `VSFR_SS_LAST) begin
                    softStartDone <= 1'b1;
                end else begin
                    csLimitStep <= csLimitStep + 2'h1;
                end
            end else begin
                ssCnt_r <= ssCnt_r + 32'h1;
            end
        end
    end

    // ----------------------------------------
    // valley target counter
    // ----------------------------------------
    logic [31:0]    perCnt_r;
    vsfr_flags_type flags_r;
    logic           periodEnd;

    assign periodEnd = perCnt_r >= 32'(PERIOD_CYC - 1);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            perCnt_r       <= 32'h0;
            highLineSelect <= 1'b0;
        end else if (clkEn) begin
            perCnt_r       <= periodEnd ? 32'h0 : perCnt_r + 32'h1;
            highLineSelect <= lineS2_r;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flags_r <= '0;
        end else if (clkEn) begin
            if (periodEnd) begin
                flags_r <= '0;
            end else begin
                flags_r.sawLow   <= flags_r.sawLow   | fbS2_r.lowHold;
                flags_r.sawHigh  <= flags_r.sawHigh  | fbS2_r.highHold;
                flags_r.sawReset <= flags_r.sawReset | fbS2_r.resetLevel;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            valleyTarget <= `VSFR_TARGET_MIN;
        end else if (clkEn) begin
            if (state_r == VSFR_IDLE) begin
                valleyTarget <= `VSFR_TARGET_MIN;
            end else if (fbS2_r.resetLevel) begin
                valleyTarget <= `VSFR_TARGET_MIN;
            end else if (periodEnd) begin
                if (flags_r.sawReset) begin
                    valleyTarget <= `VSFR_TARGET_MIN;
                end else if (flags_r.sawHigh || fbS2_r.highHold) begin
                    if (valleyTarget != `VSFR_TARGET_MIN) begin
                        valleyTarget <= valleyTarget - 3'h1;
                    end
                end else if (!(flags_r.sawLow || fbS2_r.lowHold)) begin
                    if (valleyTarget != `VSFR_TARGET_MAX) begin
                        valleyTarget <= valleyTarget + 3'h1;
                    end
                end
                // otherwise hold
            end
        end
    end

endmodule

// *** tb/vsfr_core_assertions.sv ***
// concurrent checks on the ports of the control core
`timescale 1ns/100ps
module vsfr_core_assertions (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // analog inputs
    input wire logic       supplyTurnOn,
    input wire logic       currentTrip,
    input wire logic       outputOvervoltage,
    // control outputs
    input wire logic       gateDrive,
    input wire logic       startupChargeEn,
    input wire logic [2:0] valleyTarget,
    input wire logic [2:0] valleyCount,
    input wire logic       latchedOff
);
    logic [11:0] offCnt_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // cycles the gate has been off, saturating
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            offCnt_r <= 12'h000;
        end else if (gateDrive) begin
            offCnt_r <= 12'h000;
        end else if (offCnt_r != 12'hfff) begin
            offCnt_r <= offCnt_r + 12'h001;
        end
    end
    property p_charge; $fell(startupChargeEn) |-> $past(supplyTurnOn, 3); endproperty
    a_charge: assert property (p_charge) else $error("charger off without supply");
    property p_trip; currentTrip |-> ##[1:4] !gateDrive; endproperty
    a_trip: assert property (p_trip) else $error("gate stays on after trip");
    property p_step;
        $changed(valleyTarget) |-> valleyTarget == 3'h1
            || valleyTarget - $past(valleyTarget) == 3'h1
            || $past(valleyTarget) - valleyTarget == 3'h1;
    endproperty
    a_step: assert property (p_step) else $error("target jumped");
    property p_clear; $rose(gateDrive) |-> ##[0:1] valleyCount == 3'h0; endproperty
    a_clear: assert property (p_clear) else $error("valley count kept at turn-on");
    property p_count;
        $changed(valleyCount) |-> (gateDrive && valleyCount == 3'h0)
            || valleyCount - $past(valleyCount) == 3'h1;
    endproperty
    a_count: assert property (p_count) else $error("valley count step");
    property p_on;
        $rose(gateDrive) |-> $past(offCnt_r) >= 12'h07d
            && ($past(valleyCount) >= $past(valleyTarget) || $past(offCnt_r) >= 12'h9c3);
    endproperty
    a_on: assert property (p_on) else $error("early turn-on");
    property p_maxoff; !startupChargeEn && !latchedOff |-> offCnt_r <= 12'h9c4; endproperty
    a_maxoff: assert property (p_maxoff) else $error("off time too long");
    property p_latch; latchedOff |=> latchedOff && !gateDrive; endproperty
    a_latch: assert property (p_latch) else $error("latch released");
    property p_blank; $rose(latchedOff) |-> $past(outputOvervoltage, 40); endproperty
    a_blank: assert property (p_blank) else $error("latch without blanking");
endmodule
bind vsfr_core vsfr_core_assertions u_vsfr_core_assertions (
    .core_clk(core_clk), .resetn(resetn), .supplyTurnOn(supplyTurnOn),
    .currentTrip(currentTrip), .outputOvervoltage(outputOvervoltage),
    .gateDrive(gateDrive), .startupChargeEn(startupChargeEn),
    .valleyTarget(valleyTarget), .valleyCount(valleyCount), .latchedOff(latchedOff)
);

// *** tb/vsfr_front_end.sv ***
// front end model: valley ringing after switch-off and current trip
`timescale 1ns/100ps
module vsfr_front_end (
    // clock and gate
    input  wire logic       core_clk,
    input  wire logic       gateDrive,
    // valleys rung out per off time
    input  wire logic [2:0] nValleys,
    // comparator outputs
    output logic            valleySense = 1'b1,
    output logic            currentTrip = 1'b0
);
    logic gatePrev = 1'b0;
    int   tick     = 0;
    always @(posedge core_clk) begin
        gatePrev <= gateDrive;
        tick <= (gateDrive != gatePrev) ? 0 : tick + 1;
        // clamped low while on, one fall per ring period for the first nValleys periods while off
        valleySense <= !gateDrive
            && !(tick >= 40 && tick % 40 < 20 && tick / 40 <= nValleys);
        currentTrip <= gateDrive && tick >= 20;
    end
endmodule

// *** tb/vsfr_core_bench.sv ***
// self-checking bench of the valley switching frequency reducer core
`timescale 1ns/100ps
module vsfr_core_bench;
    import vsfr_pkg::*;
    // level, target after first and after second period
    localparam logic [8:0] ROWS [11] = '{9'h01c, 9'h02e, 9'h03f, 9'h13f, 9'h1b5, 9'h1a3,
        9'h191, 9'h189, 9'h00a, 9'h1c9, 9'h00a};
    logic        core_clk          = 1'b0;
    logic        resetn            = 1'b0;
    logic        clkEn             = 1'b1;
    logic        supplyTurnOn      = 1'b0;
    logic        outputOvervoltage = 1'b0;
    logic        highLine          = 1'b0;
    vsfr_fb_type feedbackPin       = 3'h7;
    logic [2:0]  nValleys          = 3'h7;
    logic        valleySense;
    logic        currentTrip;
    logic        gateDrive;
    logic        startupChargeEn;
    logic        softStartDone;
    logic        highLineSelect;
    logic        latchedOff;
    logic [1:0]  csLimitStep;
    logic [2:0]  valleyTarget;
    logic [2:0]  valleyCount;
    int          nFail             = 0;
    int          totalChecks       = 0;
    int          n;
    vsfr_core #(.PERIOD_CYC(200), .SS_STEP_CYC(50)) u_vsfr_core (
        .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .supplyTurnOn(supplyTurnOn),
        .valleySense(valleySense), .outputOvervoltage(outputOvervoltage),
        .currentTrip(currentTrip), .highLine(highLine), .feedbackPin(feedbackPin),
        .gateDrive(gateDrive), .startupChargeEn(startupChargeEn), .csLimitStep(csLimitStep),
        .softStartDone(softStartDone), .highLineSelect(highLineSelect),
        .valleyTarget(valleyTarget), .valleyCount(valleyCount), .latchedOff(latchedOff)
    );
    vsfr_front_end u_vsfr_front_end (
        .core_clk(core_clk), .gateDrive(gateDrive), .nValleys(nValleys),
        .valleySense(valleySense), .currentTrip(currentTrip)
    );
    always #10 core_clk = ~core_clk;
    task automatic check(input logic [2:0] got, input logic [2:0] exp, input string what);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic printVerdict();
        $display("checks %0d, mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic guard(input int lim);
        if (n >= lim) begin
            nFail++;
            $display("wrong value at %0t: wait timed out", $time);
            printVerdict();
        end
    endtask
    task automatic ticks(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic waitGate(input logic lvl);
        n = 0;
        while (gateDrive !== lvl && n < 3000) begin
            ticks(1);
            n++;
        end
        guard(3000);
    endtask
    initial begin
        ticks(5);
        resetn = 1'b1;
        check({gateDrive, startupChargeEn, latchedOff}, 3'h2, "reset outputs");
        check(valleyTarget, 3'h1, "reset target");
        supplyTurnOn = 1'b1;
        n = 0;
        while (softStartDone !== 1'b1 && n < 400) begin
            ticks(1);
            n++;
        end
        guard(400);
        check({csLimitStep, startupChargeEn}, 3'h6, "soft start end");
        check({2'h0, n >= 195 && n <= 215}, 3'h1, "soft start time");
        $display("test start done");
        feedbackPin = 3'h0;
        n = 0;
        while (valleyTarget !== 3'h2 && n < 500) begin
            ticks(1);
            n++;
        end
        guard(500);
        foreach (ROWS[i]) begin
            feedbackPin = ROWS[i][8:6];
            ticks(200);
            check(valleyTarget, ROWS[i][5:3], "target, first period");
            ticks(200);
            check(valleyTarget, ROWS[i][2:0], "target, second period");
        end
        feedbackPin = 3'h7;
        ticks(4);
        check(valleyTarget, 3'h1, "reset level");
        highLine = 1'b1;
        ticks(4);
        check({2'h0, highLineSelect}, 3'h1, "line select high");
        highLine = 1'b0;
        ticks(4);
        check({2'h0, highLineSelect}, 3'h0, "line select low");
        $display("test target counter done");
        nValleys = 3'h1;
        waitGate(1'b1);
        waitGate(1'b0);
        waitGate(1'b1);
        check({2'h0, n >= 122 && n <= 135}, 3'h1, "off time after valley");
        nValleys = 3'h0;
        waitGate(1'b0);
        waitGate(1'b1);
        check({2'h0, n >= 2490 && n <= 2510}, 3'h1, "max off time");
        $display("test gate timing done");
        for (int k = 0; k < 2; k++) begin
            waitGate(1'b1);
            waitGate(1'b0);
            outputOvervoltage = 1'b1;
            ticks(k ? 80 : 20);
            outputOvervoltage = 1'b0;
            ticks(5);
            check({gateDrive, 1'b0, latchedOff}, {2'h0, k == 1}, "overvoltage latch");
        end
        $display("test overvoltage done");
        // frozen clock enable must hold the line select
        clkEn = 1'b0;
        highLine = 1'b1;
        ticks(6);
        check({2'h0, highLineSelect}, 3'h0, "line select frozen");
        clkEn = 1'b1;
        ticks(4);
        check({2'h0, highLineSelect}, 3'h1, "line select resumed");
        $display("test clock enable done");
        printVerdict();
    end
endmodule
